// *** hdl/ahs_pkg.sv ***
// Shared constants, register layouts and types for the home search block.
// Assumes a single 100 MHz clock and the documented register port.
//
// What this block does
// - Step 1 runs fast until detect, then stops after DECEL_CNT more fast pulses
// - Step 2 escapes active detect, then searches slowly
// - Step 1 overshoot reverses once, then Step 2
// - Overshoot reversal only with matching signal and direction
// - Detect active at start skips Step 1
// - Limit in Step 1 starts reverse-away Step 2
// - Step 4 emits offset pulses; disabled steps skipped, but Step 2 runs after a Step 1 limit or a detect at start
// - Mode word 1 decodes Step 1 fields D3..D0
// - Mode word 1 decodes Step 2 fields D9..D4
// - Mode word 1 decodes Step 3 fields, D15 Step 4
// - Mode word 2 clears counters at search end after Step 2, 3 or 4
// - Mode word 2 sets timer and clear pulse shape
// - Filter delay code and per-input filter enables
// - Detect level from level bit, limits gated by enable
// - Error bit stays set when search fails
package ahs_pkg;

    // Clock and timing
    localparam int CLK_HZ = 100_000_000;
    localparam int HIGH_PPS = 20_000;
    localparam int LOW_PPS = 500;
    localparam int HIGH_PER_CYC = CLK_HZ / HIGH_PPS;
    localparam int LOW_PER_CYC = CLK_HZ / LOW_PPS;
    localparam int FILT_UNIT_NS = 1000;
    localparam int FILT_UNIT_CYC = FILT_UNIT_NS / (1_000_000_000 / CLK_HZ);
    localparam int WAIT_UNIT_US = 1000;
    localparam int WAIT_UNIT_CYC = WAIT_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int DCC_UNIT_US = 10;
    localparam int DCC_UNIT_CYC = DCC_UNIT_US * (CLK_HZ / 1_000_000);
    localparam int DECEL_PULSES = 16;

    // Register port addresses
    localparam logic [2:0] ADDR_CMD = 3'h0;
    localparam logic [2:0] ADDR_LEVEL = 3'h2;
    localparam logic [2:0] ADDR_DATA = 3'h6;

    // Command codes (low byte), axis mask sits in bits 11..8
    localparam logic [7:0] CMD_AXIS_SEL = 8'h1F;
    localparam logic [7:0] CMD_FILTER = 8'h25;
    localparam logic [7:0] CMD_MODE1 = 8'h23;
    localparam logic [7:0] CMD_MODE2 = 8'h24;
    localparam logic [7:0] CMD_OFFSET = 8'h06;
    localparam logic [7:0] CMD_START = 8'h5A;
    localparam int AXIS_FIELD_LSB = 8;

    // Level register bit positions
    localparam int LVL_STOP0_BIT = 0;
    localparam int LVL_STOP1_BIT = 2;
    localparam int LVL_STOP2_BIT = 4;
    localparam int LIMIT_EN_BIT = 11;

    // Reset values
    localparam logic [15:0] REG_RESET = 16'h0000;

    // Filtered input indices
    localparam int IN_LMTP = 0;
    localparam int IN_LMTM = 1;
    localparam int IN_STOP1 = 2;
    localparam int IN_STOP0 = 3;
    localparam int IN_STOP2 = 4;
    localparam int NUM_IN = 5;

    // Step 1 detection signal codes
    localparam logic [1:0] DET1_STOP0 = 2'h0;
    localparam logic [1:0] DET1_STOP1 = 2'h1;
    localparam logic [1:0] DET1_LIMIT = 2'h2;
    localparam logic [1:0] DET1_STOP2 = 2'h3;

    // Mode word 1, D15 down to D0
    typedef struct packed {
        logic s4_en;
        logic s3_lp_clr;
        logic s3_rp_clr;
        logic s3_dcc;
        logic s3_dir;
        logic s3_en;
        logic s2_lp_clr;
        logic s2_rp_clr;
        logic s2_dcc;
        logic s2_det;
        logic s2_dir;
        logic s2_en;
        logic [1:0] s1_det;
        logic s1_dir;
        logic s1_en;
    } ahs_mode1_s;

    // Mode word 2, D15 down to D0
    typedef struct packed {
        logic [4:0] rsv_hi;
        logic [2:0] timer_code;
        logic timer_en;
        logic [2:0] dcc_width;
        logic dcc_pol;
        logic end_lp_clr;
        logic end_rp_clr;
        logic rsv_lo;
    } ahs_mode2_s;

    // Filter setting, D15 down to D0
    typedef struct packed {
        logic [3:0] rsv_hi;
        logic [3:0] delay_code;
        logic [2:0] rsv_mid;
        logic [4:0] en;
    } ahs_filter_s;

    // Sequencer states
    typedef enum logic [3:0] {
        ST_IDLE, ST_S1, ST_S1_DECEL, ST_S1_BACK, ST_S2_LIM,
        ST_S2_ESC, ST_S2_SRCH, ST_S3, ST_S4, ST_WAIT
    } ahs_state_e;

endpackage : ahs_pkg

// *** hdl/ahs_input_filter.sv ***
// Input synchroniser and stability filter for the sensor inputs.
// Assumes raw inputs are asynchronous; output changes only after the
// input has held a new level for the selected delay.
`timescale 1ns/1ns
module ahs_input_filter #(
    parameter int NUM = 5,
    parameter int UNIT_CYC = 100
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [NUM-1:0] raw_i,
    input wire logic [NUM-1:0] en_i,
    input wire logic [3:0] code_i,
    output logic [NUM-1:0] filt_o
);

    // Delay in cycles, code 0 means no delay
    logic [31:0] delay_cyc;
    always_comb
    begin
        if (code_i == 4'h0)
            delay_cyc = 32'h0000_0000;
        else
            delay_cyc = 32'(UNIT_CYC) << (code_i - 4'h1);
    end

    // One synchroniser and filter per input
    genvar g;
    generate
        for (g = 0; g < NUM; g++)
        begin : g_in
            logic sync1_reg; // First stage, read only by second
            logic sync2_reg;
            logic out_reg;
            logic [31:0] cnt_reg;

            // Two-stage synchroniser
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    sync1_reg <= 1'b0;
                    sync2_reg <= 1'b0;
                end
                else
                begin
                    sync1_reg <= raw_i[g];
                    sync2_reg <= sync1_reg;
                end
            end

            // Stability counter
            always_ff @(posedge clk_i)
            begin
                if (!rst_n_i)
                begin
                    out_reg <= 1'b0;
                    cnt_reg <= 32'h0000_0000;
                end
                else if (!en_i[g] || delay_cyc == 32'h0000_0000)
                begin
                    // Filter bypassed
                    out_reg <= sync2_reg;
                    cnt_reg <= 32'h0000_0000;
                end
                else if (sync2_reg == out_reg)
                    cnt_reg <= 32'h0000_0000;
                else if (cnt_reg >= delay_cyc - 32'h0000_0001)
                begin
                    // New level held long enough
                    out_reg <= sync2_reg;
                    cnt_reg <= 32'h0000_0000;
                end
                else
                    cnt_reg <= cnt_reg + 32'h0000_0001;
            end

            assign filt_o[g] = out_reg;
        end
    endgenerate

endmodule : ahs_input_filter

// *** hdl/ahs_home_search.sv ***
// Automatic home search sequencer for one axis.
// Assumes host writes arrive as single-cycle strobes on the REF_CLK_I
// domain; sensors and limits are asynchronous pins.
`timescale 1ns/1ns
module ahs_home_search #(
    parameter int AXIS_BIT = 0,
    parameter int HIGH_PER = ahs_pkg::HIGH_PER_CYC,
    parameter int LOW_PER = ahs_pkg::LOW_PER_CYC,
    parameter int WAIT_UNIT = ahs_pkg::WAIT_UNIT_CYC,
    parameter int DCC_UNIT = ahs_pkg::DCC_UNIT_CYC,
    parameter int DECEL_CNT = ahs_pkg::DECEL_PULSES
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic REG_WR_I,
    input wire logic [2:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic AUX_DETECT_I,
    input wire logic HOME_DETECT_I,
    input wire logic ENCODER_INDEX_I,
    input wire logic LIMIT_PLUS_I,
    input wire logic LIMIT_MINUS_I,
    output logic PULSE_O,
    output logic DIR_O,
    output logic BUSY_O,
    output logic ERROR_O,
    output logic LP_CLEAR_O,
    output logic RP_CLEAR_O,
    output logic DEVIATION_CLEAR_O
);
    import ahs_pkg::*;

    logic axis_sel_reg; // Axis chosen by select command
    logic [15:0] input_level_write_reg; // Levels and limit enable
    logic [15:0] param_data_write_reg; // Data staged for commands
    ahs_filter_s filter_reg;
    ahs_mode1_s home_search_step_config;
    ahs_mode2_s home_search_timer_clear_config;
    logic [15:0] offset_reg; // Signed offset pulse count
    ahs_state_e state_reg;
    logic [2:0] pend_reg; // Step to enter after wait
    logic [31:0] timer_reg;
    logic [31:0] div_reg;
    logic [15:0] cnt_reg; // Offset or decel pulses left
    logic prev_idx_reg; // Index level last cycle
    logic [31:0] dcc_cnt_reg;
    logic [NUM_IN-1:0] filt;

    // Command decode
    logic cmd_wr;
    logic axis_hit;
    logic [7:0] cmd_code;
    assign cmd_wr = REG_WR_I && (REG_ADDR_I == ADDR_CMD);
    assign axis_hit = REG_WDATA_I[AXIS_FIELD_LSB + AXIS_BIT];
    assign cmd_code = REG_WDATA_I[7:0];

    // Host register writes
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            axis_sel_reg <= 1'b0;
            input_level_write_reg <= REG_RESET;
            param_data_write_reg <= REG_RESET;
            filter_reg <= REG_RESET;
            home_search_step_config <= REG_RESET;
            home_search_timer_clear_config <= REG_RESET;
            offset_reg <= REG_RESET;
        end
        else if (REG_WR_I)
        begin
            if (REG_ADDR_I == ADDR_DATA)
                param_data_write_reg <= REG_WDATA_I;
            else if (REG_ADDR_I == ADDR_LEVEL && axis_sel_reg)
                input_level_write_reg <= REG_WDATA_I;
            else if (cmd_wr && cmd_code == CMD_AXIS_SEL)
                axis_sel_reg <= axis_hit;
            else if (cmd_wr && axis_hit)
            begin
                // Load staged data by command code
                unique case (cmd_code)
                    CMD_FILTER: filter_reg <= param_data_write_reg;
                    CMD_MODE1: home_search_step_config <= param_data_write_reg;
                    CMD_MODE2:
                        home_search_timer_clear_config <= param_data_write_reg;
                    CMD_OFFSET: offset_reg <= param_data_write_reg;
                    default: ;
                endcase
            end
        end
    end

    // Synchronise and filter sensors
    ahs_input_filter #(.NUM(NUM_IN), .UNIT_CYC(FILT_UNIT_CYC)) u_filter (
        .clk_i(REF_CLK_I),
        .rst_n_i(RST_N_I),
        .raw_i({ENCODER_INDEX_I, AUX_DETECT_I, HOME_DETECT_I,
                LIMIT_MINUS_I, LIMIT_PLUS_I}),
        .en_i(filter_reg.en),
        .code_i(filter_reg.delay_code),
        .filt_o(filt)
    );

    // Active levels, level bit 1 means high active, limits gated by the enable bit
    ahs_mode1_s m1;
    ahs_mode2_s m2;
    logic stop0_act, stop1_act, stop2_act, lim_p, lim_m;
    assign m1 = home_search_step_config;
    assign m2 = home_search_timer_clear_config;
    assign stop0_act = filt[IN_STOP0]
        ~^ input_level_write_reg[LVL_STOP0_BIT];
    assign stop1_act = filt[IN_STOP1]
        ~^ input_level_write_reg[LVL_STOP1_BIT];
    assign stop2_act = filt[IN_STOP2]
        ~^ input_level_write_reg[LVL_STOP2_BIT];
    assign lim_p = filt[IN_LMTP] & input_level_write_reg[LIMIT_EN_BIT];
    assign lim_m = filt[IN_LMTM] & input_level_write_reg[LIMIT_EN_BIT];

    // Detection signal selection, direction 1 is minus
    logic det1, det2;
    always_comb
    begin
        unique case (m1.s1_det)
            DET1_STOP0: det1 = stop0_act;
            DET1_STOP1: det1 = stop1_act;
            DET1_LIMIT: det1 = m1.s1_dir ? lim_m : lim_p;
            DET1_STOP2: det1 = stop2_act;
        endcase
        det2 = m1.s2_det ? (m1.s2_dir ? lim_m : lim_p) : stop1_act;
    end

    // Motion per state
    logic moving, fast, mv_dir, lim_fwd;
    always_comb
    begin
        moving = 1'b1;
        fast = 1'b0;
        mv_dir = 1'b0;
        unique case (state_reg)
            ST_S1, ST_S1_DECEL:
            begin
                fast = 1'b1;
                mv_dir = m1.s1_dir;
            end
            ST_S1_BACK, ST_S2_ESC: mv_dir = ~m1.s2_dir;
            ST_S2_LIM: mv_dir = ~m1.s1_dir;
            ST_S2_SRCH: mv_dir = m1.s2_dir;
            ST_S3: mv_dir = m1.s3_dir;
            ST_S4:
            begin
                fast = 1'b1;
                mv_dir = offset_reg[15];
            end
            default: moving = 1'b0;
        endcase
        lim_fwd = mv_dir ? lim_m : lim_p;
    end

    // Pulse rate divider
    logic tick;
    logic [31:0] per;
    assign per = fast ? 32'(HIGH_PER) : 32'(LOW_PER);
    assign tick = moving && (div_reg >= per - 32'h0000_0001);
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I || !moving || tick)
            div_reg <= 32'h0000_0000;
        else
            div_reg <= div_reg + 32'h0000_0001;
    end

    // First enabled step after step k, zero when none
    function automatic logic [2:0] next_step(input logic [2:0] k,
                                             input ahs_mode1_s m);
        logic [3:0] en;
        logic [2:0] res;
        en = {m.s4_en, m.s3_en, m.s2_en, m.s1_en};
        res = 3'h0;
        for (int j = 4; j >= 1; j--)
            if (3'(j) > k && en[j-1])
                res = 3'(j);
        return res;
    endfunction : next_step

    // Sequencing decisions
    logic fin; // Step k completed or search started
    logic [2:0] fin_step;
    logic go; // Enter step tgt now
    logic [2:0] tgt;
    logic abort;
    logic overshoot_ok;
    assign overshoot_ok = m1.s2_en && (m1.s1_dir == m1.s2_dir) &&
        (m1.s2_det ? (m1.s1_det == DET1_LIMIT)
                   : (m1.s1_det == DET1_STOP1));
    always_comb
    begin
        fin = 1'b0;
        fin_step = 3'h0;
        abort = 1'b0;
        unique case (state_reg)
            ST_IDLE: fin = cmd_wr && axis_hit && cmd_code == CMD_START;
            ST_S2_SRCH:
            begin
                fin = det2;
                fin_step = 3'h2;
                abort = !det2 && lim_fwd;
            end
            ST_S3:
            begin
                fin = stop2_act && !prev_idx_reg;
                fin_step = 3'h3;
                abort = !fin && lim_fwd;
            end
            ST_S4:
            begin
                fin = (cnt_reg == 16'h0000);
                fin_step = 3'h4;
                abort = !fin && lim_fwd;
            end
            ST_S1_BACK, ST_S2_LIM, ST_S2_ESC: abort = lim_fwd;
            default: ;
        endcase
        tgt = next_step(fin_step, m1);
        go = fin && !(m2.timer_en && fin_step != 3'h0 && tgt != 3'h0);
        if (state_reg == ST_WAIT && timer_reg == 32'h0000_0000)
        begin
            go = 1'b1;
            tgt = pend_reg;
        end
    end

    // Main sequencer
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            state_reg <= ST_IDLE;
            pend_reg <= 3'h0;
            timer_reg <= 32'h0000_0000;
            cnt_reg <= 16'h0000;
            ERROR_O <= 1'b0;
        end
        else if (abort)
        begin
            state_reg <= ST_IDLE;
            ERROR_O <= 1'b1;
        end
        else if (go)
        begin
            if (fin && fin_step == 3'h0)
                ERROR_O <= 1'b0;
            unique case (tgt)
                3'h1: state_reg <= det1 ? ST_S2_ESC : ST_S1;
                3'h2: state_reg <= det2 ? ST_S2_ESC : ST_S2_SRCH;
                3'h3:
                begin
                    state_reg <= stop2_act ? ST_IDLE : ST_S3;
                    if (stop2_act)
                        ERROR_O <= 1'b1;
                end
                3'h4:
                begin
                    state_reg <= ST_S4;
                    // Magnitude of signed offset
                    cnt_reg <= offset_reg[15] ? 16'(-offset_reg)
                                              : offset_reg;
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
        else if (fin)
        begin
            // Inter-step wait
            state_reg <= ST_WAIT;
            pend_reg <= tgt;
            timer_reg <= 32'(WAIT_UNIT * (int'(m2.timer_code) + 1));
        end
        else
        begin
            unique case (state_reg)
                ST_S1:
                    if (det1)
                    begin
                        state_reg <= ST_S1_DECEL;
                        cnt_reg <= 16'(DECEL_CNT);
                    end
                    else if (lim_fwd)
                        state_reg <= ST_S2_LIM;
                ST_S1_DECEL:
                    if (cnt_reg == 16'h0000 || lim_fwd)
                    begin
                        // Stopped; overshot past the active section?
                        if (!det2 && overshoot_ok)
                            state_reg <= ST_S1_BACK;
                        else if (m1.s2_en)
                            state_reg <= det2 ? ST_S2_ESC : ST_S2_SRCH;
                        else
                        begin
                            state_reg <= ST_WAIT;
                            pend_reg <= next_step(3'h1, m1);
                            timer_reg <= m2.timer_en ?
                                32'(WAIT_UNIT * (int'(m2.timer_code) + 1))
                                : 32'h0000_0000;
                        end
                    end
                    else if (tick)
                        cnt_reg <= cnt_reg - 16'h0001;
                ST_S1_BACK, ST_S2_LIM:
                    if (det2)
                        state_reg <= ST_S2_ESC;
                ST_S2_ESC:
                    if (!det2)
                        state_reg <= ST_S2_SRCH;
                ST_S4:
                    if (tick)
                        cnt_reg <= cnt_reg - 16'h0001;
                ST_WAIT: timer_reg <= timer_reg - 32'h0000_0001;
                default: ;
            endcase
        end
    end

    // Index edge history and pulse outputs
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            prev_idx_reg <= 1'b0;
            PULSE_O <= 1'b0;
            DIR_O <= 1'b0;
        end
        else
        begin
            prev_idx_reg <= stop2_act;
            PULSE_O <= tick;
            // Direction held while stopped, so it never moves when idle
            if (moving)
                DIR_O <= mv_dir;
        end
    end

    // Counter clears and deviation clear pulse
    logic done2, done3, last;
    assign done2 = fin && fin_step == 3'h2;
    assign done3 = fin && fin_step == 3'h3;
    assign last = fin && fin_step != 3'h0 && tgt == 3'h0 && go;
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
        begin
            LP_CLEAR_O <= 1'b0;
            RP_CLEAR_O <= 1'b0;
            dcc_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            LP_CLEAR_O <= (done2 && m1.s2_lp_clr) || (done3 && m1.s3_lp_clr)
                || (last && m2.end_lp_clr);
            RP_CLEAR_O <= (done2 && m1.s2_rp_clr) || (done3 && m1.s3_rp_clr)
                || (last && m2.end_rp_clr);
            if ((done2 && m1.s2_dcc) || (done3 && m1.s3_dcc))
                dcc_cnt_reg <=
                    32'(DCC_UNIT * (int'(m2.dcc_width) + 1));
            else if (dcc_cnt_reg != 32'h0000_0000)
                dcc_cnt_reg <= dcc_cnt_reg - 32'h0000_0001;
        end
    end

    // Polarity applied to the clear pulse level
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            DEVIATION_CLEAR_O <= 1'b0;
        else
            DEVIATION_CLEAR_O <= (dcc_cnt_reg != 32'h0000_0000)
                ~^ m2.dcc_pol;
    end

    // Busy while sequencer is active
    assign BUSY_O = (state_reg != ST_IDLE);

endmodule : ahs_home_search

// *** verification/ahs_home_search_chk.sv ***
// Port checker for the home search sequencer.
// Assumes it is bound onto every ahs_home_search.
`timescale 1ns/1ns
module ahs_home_search_chk #(
    parameter int HIGH_PER = 4
) (
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    input wire logic REG_WR_I,
    input wire logic [2:0] REG_ADDR_I,
    input wire logic [15:0] REG_WDATA_I,
    input wire logic PULSE_O,
    input wire logic DIR_O,
    input wire logic BUSY_O,
    input wire logic ERROR_O,
    input wire logic LP_CLEAR_O,
    input wire logic RP_CLEAR_O
);
    import ahs_pkg::*;
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    logic start_w; // Start command with axis bit 8 set
    logic [3:0] gap_reg; // Cycles since the last pulse
    assign start_w = REG_WR_I && REG_ADDR_I == ADDR_CMD
        && REG_WDATA_I[7:0] == CMD_START && REG_WDATA_I[8];
    // Saturating pulse spacing counter
    always_ff @(posedge REF_CLK_I)
    begin
        if (!RST_N_I)
            gap_reg <= 4'hf;
        else if (PULSE_O)
            gap_reg <= 4'h0;
        else if (gap_reg != 4'hf)
            gap_reg <= gap_reg + 4'h1;
    end
    chk_busy_start: assert property (
        start_w && !BUSY_O |=> BUSY_O) else $error("busy not raised");
    chk_busy_hold: assert property (
        !BUSY_O && !start_w |=> !BUSY_O) else $error("busy unprompted");
    chk_pulse_busy: assert property (
        PULSE_O |-> $past(BUSY_O)) else $error("pulse while idle");
    chk_pulse_gap: assert property (
        PULSE_O |-> gap_reg >= HIGH_PER - 1) else $error("pulses too close");
    chk_dir_idle: assert property (
        $changed(DIR_O) |-> BUSY_O || $past(BUSY_O))
        else $error("direction moved while idle");
    chk_error_hold: assert property (
        ERROR_O && !start_w |=> ERROR_O) else $error("error bit dropped");
    chk_lp_single: assert property (
        LP_CLEAR_O |=> !LP_CLEAR_O) else $error("long position clear");
    chk_rp_single: assert property (
        RP_CLEAR_O |=> !RP_CLEAR_O) else $error("long real clear");
    chk_clear_busy: assert property (
        LP_CLEAR_O |-> BUSY_O || $past(BUSY_O)) else $error("idle clear");
endmodule : ahs_home_search_chk

bind ahs_home_search ahs_home_search_chk #(.HIGH_PER(HIGH_PER)) chk_i (
    .REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I), .REG_WR_I(REG_WR_I),
    .REG_ADDR_I(REG_ADDR_I), .REG_WDATA_I(REG_WDATA_I),
    .PULSE_O(PULSE_O), .DIR_O(DIR_O), .BUSY_O(BUSY_O),
    .ERROR_O(ERROR_O), .LP_CLEAR_O(LP_CLEAR_O), .RP_CLEAR_O(RP_CLEAR_O));

// *** verification/ahs_sensor_model.sv ***
// Axis model: shaft position, home window, index and limits.
// Assumes one step per drive pulse, direction high meaning minus.
`timescale 1ns/1ns
module ahs_sensor_model (
    input wire logic clk_i,
    input wire logic pulse_i,
    input wire logic dir_i,
    input wire logic load_i,
    input wire logic signed [31:0] start_i,
    input wire logic signed [31:0] lo_i,
    input wire logic signed [31:0] hi_i,
    input wire logic home_hi_i,
    input wire logic idx_act_i,
    output logic aux_o,
    output logic home_o,
    output logic index_o,
    output logic lim_p_o,
    output logic lim_m_o,
    output logic signed [31:0] pos_o
);
    // Position follows the drive pulses
    always @(posedge clk_i)
    begin
        if (load_i)
            pos_o <= start_i;
        else if (pulse_i)
            pos_o <= dir_i ? pos_o - 1 : pos_o + 1;
    end
    // Home level inside the window, polarity as programmed
    assign home_o = ((pos_o >= lo_i) && (pos_o <= hi_i)) == home_hi_i;
    assign index_o = !idx_act_i; // Low active, quiet unless forced
    assign aux_o = 1'b1; // Low active, never reached
    assign lim_m_o = pos_o <= -50; // Minus end stop, active high
    assign lim_p_o = pos_o >= 100000; // Plus end stop, out of reach
endmodule : ahs_sensor_model

// *** verification/ahs_home_search_tb.sv ***
// Self-checking bench for the home search sequencer.
// Assumes the axis model drives every sensor pin.
`timescale 1ns/1ns
module ahs_home_search_tb;
    import ahs_pkg::*;
    localparam int DCC_U = 3; // Shortened clear pulse unit
    logic ref_clk = 1'b0; // 100 MHz clock
    logic rst_n = 1'b0; // Reset, active low
    logic wr = 1'b0; // Register write strobe
    logic [2:0] addr = 3'h0; // Register select
    logic [15:0] wdata = 16'h0000; // Write data
    logic load = 1'b1; // Model position load
    logic home_hi = 1'b0; // Model home polarity
    logic idx_act = 1'b0; // Force index active
    logic signed [31:0] start_p = 0, lo = 0, hi = 0; // Axis layout
    logic pulse, dir, busy, err, lp_clr, rp_clr, dcc; // Design outputs
    logic aux, home, index, lim_p, lim_m; // Sensor pins
    logic signed [31:0] pos; // Shaft position
    logic [31:0] rnd_reg = 32'h0000_dee3; // Random state
    int error_cnt = 0, checks = 0, lp_n = 0, rp_n = 0, dcc_n = 0;
    ahs_home_search #(.HIGH_PER(4), .LOW_PER(8), .WAIT_UNIT(5),
        .DCC_UNIT(DCC_U), .DECEL_CNT(2)) ahs_home_search_i (
        .REF_CLK_I(ref_clk), .RST_N_I(rst_n), .REG_WR_I(wr),
        .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .AUX_DETECT_I(aux),
        .HOME_DETECT_I(home), .ENCODER_INDEX_I(index),
        .LIMIT_PLUS_I(lim_p), .LIMIT_MINUS_I(lim_m), .PULSE_O(pulse),
        .DIR_O(dir), .BUSY_O(busy), .ERROR_O(err), .LP_CLEAR_O(lp_clr),
        .RP_CLEAR_O(rp_clr), .DEVIATION_CLEAR_O(dcc));
    ahs_sensor_model ahs_sensor_model_i (.clk_i(ref_clk),
        .pulse_i(pulse), .dir_i(dir), .load_i(load), .start_i(start_p),
        .lo_i(lo), .hi_i(hi), .home_hi_i(home_hi), .idx_act_i(idx_act),
        .aux_o(aux), .home_o(home), .index_o(index), .lim_p_o(lim_p),
        .lim_m_o(lim_m), .pos_o(pos));
    // Clock generator
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // Count clear pulses and active clear cycles
    always @(posedge ref_clk)
    begin
        lp_n += (lp_clr === 1'b1);
        rp_n += (rp_clr === 1'b1);
        dcc_n += (dcc === 1'b0);
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs
    task automatic end_of_test;
        if (error_cnt == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    task automatic check(input string name, input logic [31:0] seen, exp);
        checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %0h seen %0h", name, exp, seen);
        end
    endtask : check
    // One register write, strobe high for one cycle
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(negedge ref_clk);
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(negedge ref_clk);
        wr = 1'b0;
    endtask : wr_reg
    // Program, start, wait, then compare with the expected values
    task automatic run_case(input int sp, l, h, input logic [15:0] lvl,
        m1, m2, off, input logic ia, ee);
        int n;
        int ep;
        int ed;
        ep = ee ? h : (m1[15] ? h + int'($signed(off)) : h);
        ed = m1[7] ? (int'(m2[6:4]) + 1) * DCC_U : 0;
        start_p = sp;
        lo = l;
        hi = h;
        home_hi = lvl[LVL_STOP1_BIT];
        idx_act = ia;
        load = 1'b1;
        @(negedge ref_clk);
        load = 1'b0;
        lp_n = 0;
        rp_n = 0;
        dcc_n = 0;
        wr_reg(ADDR_CMD, 16'h011F);
        wr_reg(ADDR_LEVEL, lvl);
        wr_reg(ADDR_DATA, 16'h0A08);
        wr_reg(ADDR_CMD, 16'h0125);
        wr_reg(ADDR_DATA, m1);
        wr_reg(ADDR_CMD, 16'h0123);
        wr_reg(ADDR_DATA, m2);
        wr_reg(ADDR_CMD, 16'h0124);
        wr_reg(ADDR_DATA, off);
        wr_reg(ADDR_CMD, 16'h0106);
        wr_reg(ADDR_CMD, 16'h015A);
        @(negedge ref_clk);
        check("busy", busy, 1'b1);
        for (n = 0; n < 30000 && busy !== 1'b0; n++)
            @(negedge ref_clk);
        if (n == 30000)
        begin
            error_cnt++;
            end_of_test();
        end
        repeat (4) @(negedge ref_clk);
        check("position", pos, ep);
        check("error", err, ee);
        check("lp clear", lp_n, m2[2]);
        check("rp clear", rp_n, m2[1]);
        check("dev clear", dcc_n, ed);
    endtask : run_case
    // Main sequence
    initial
    begin
        repeat (16) @(negedge ref_clk);
        rst_n = 1'b1;
        @(negedge ref_clk);
        check("dev clear idle", dcc, 1'b1);
        rnd_reg = xs(rnd_reg);
        run_case(60 + rnd_reg[4:0], -10, 0, 16'h0800, 16'h80B7, 16'h0000,
            16'h0DAC, 1'b0, 1'b0);
        run_case(-5, -10, 0, 16'h0800, 16'h8037, 16'h0386, 16'h001E,
            1'b0, 1'b0);
        run_case(20, 0, 0, 16'h080C, 16'h8037, 16'h0000, 16'hFFEC,
            1'b0, 1'b0);
        run_case(0, 30, 40, 16'h0800, 16'h0037, 16'h0000, 16'h001E,
            1'b0, 1'b0);
        run_case(-5, -10, 0, 16'h0800, 16'h8437, 16'h0000, 16'h001E,
            1'b1, 1'b1);
        end_of_test();
    end
endmodule : ahs_home_search_tb
